// file: hdl/stl_threshold_loader.sv
// Top of the serial threshold loader and comparator output logic.
// Assumes: mode pins and analog sample codes arrive asynchronously to
// ref_clk; the serial clock is a separate domain that may stop between
// transfers.
`timescale 1ns/1ps

module stl_threshold_loader
   import stl_pkg::*;
(
   input  wire logic              ref_clk,           // Reference clock, 25 MHz
   input  wire logic              rst,               // Async reset, active high
   input  wire logic              sclk,              // Serial clock pin
   input  wire logic              sdata,             // Serial data pin
   input  wire logic              mode_select_low,   // Mode pin, low bit
   input  wire logic              mode_select_high,  // Mode pin, high bit
   input  wire logic [THR_W-1:0]  pressure_sample,   // Pressure circuit output code
   input  wire logic [THR_W-1:0]  temp_sample,       // Temperature circuit output code
   output logic [THR_W-1:0]       threshold_ref,     // Threshold to the D/A reference
   output logic                   compare_out,       // Held sample above reference
   output logic                   compare_valid,     // Comparator powered (read mode)
   output logic                   pressure_meas_en,  // Pressure circuit powered
   output logic                   temp_source_en,    // Temperature current source on
   output stl_mode_e              mode_state,        // Decoded operating mode
   output logic                   held_is_temp,      // Held sample is temperature
   output logic                   threshold_loaded,  // One-cycle pulse per new load
   output logic [THR_W-1:0]       load_count         // Loads seen since reset
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Mode pin pair to operating state
   function automatic stl_mode_e mode_decode(input logic [MODE_W-1:0] pins);
      stl_mode_e m;
      m = ST_STANDBY;
      case (pins)
         MODE_STANDBY:  m = ST_STANDBY;
         MODE_PRESSURE: m = ST_PRESSURE;
         MODE_TEMP:     m = ST_TEMP;
         MODE_READ:     m = ST_READ;
         default:       m = ST_STANDBY;
      endcase
      return m;
   endfunction

   // Serial counter runs only in standby and read
   function automatic logic counter_held(input stl_mode_e m);
      logic h;
      h = 1'b0;
      case (m)
         ST_PRESSURE: h = 1'b1;
         ST_TEMP:     h = 1'b1;
         default:     h = 1'b0;
      endcase
      return h;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [MODE_W-1:0] mode_meta;
   logic [MODE_W-1:0] mode_sync;
   logic [THR_W-1:0]  press_meta;
   logic [THR_W-1:0]  press_sync;
   logic [THR_W-1:0]  temp_meta;
   logic [THR_W-1:0]  temp_sync;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_meta <= MODE_RESET;
         mode_sync <= MODE_RESET;
      end
      else
      begin
         mode_meta <= {mode_select_high, mode_select_low};
         mode_sync <= mode_meta;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         press_meta <= SAMPLE_RESET;
         press_sync <= SAMPLE_RESET;
         temp_meta  <= SAMPLE_RESET;
         temp_sync  <= SAMPLE_RESET;
      end
      else
      begin
         press_meta <= pressure_sample;
         press_sync <= press_meta;
         temp_meta  <= temp_sample;
         temp_sync  <= temp_meta;
      end
   end

   // ****************************************************************
   // Operating mode state
   // ****************************************************************
   stl_mode_e next_mode_state;
   wire       next_measuring;
   wire       next_press;
   wire       next_temp;
   wire       next_read;

   assign next_mode_state = mode_decode(mode_sync);
   assign next_measuring  = counter_held(next_mode_state);
   assign next_press      = (next_mode_state == ST_PRESSURE);
   assign next_temp       = (next_mode_state == ST_TEMP);
   assign next_read       = (next_mode_state == ST_READ);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         mode_state <= ST_STANDBY;
      else
         mode_state <= next_mode_state;
   end

   // Measure circuit power follows the selected channel
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pressure_meas_en <= 1'b0;
         temp_source_en   <= 1'b0;
      end
      else
      begin
         pressure_meas_en <= next_press;
         temp_source_en   <= next_temp;
      end
   end

   // ****************************************************************
   // Serial counter clear
   // ****************************************************************
   // Registered so the link side sees a glitch-free async clear; it is
   // raised by either measure mode, so pulsing one mode pin high and
   // back low leaves a cleared counter behind.
   logic link_clear;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         link_clear <= 1'b0;
      else
         link_clear <= next_measuring;
   end

   // ****************************************************************
   // Serial link domain
   // ****************************************************************
   logic [THR_W-1:0] latch_word;
   logic             load_toggle;

   stl_serial_link u_link (
      .sclk        (sclk),
      .rst         (rst),
      .sdata       (sdata),
      .link_clear  (link_clear),
      .latch_word  (latch_word),
      .load_toggle (load_toggle)
   );

   // ****************************************************************
   // Latch word crossing into the reference domain
   // ****************************************************************
   // The latch word is stable for at least eight serial clocks after
   // each toggle, far longer than the three-flop toggle path.
   logic tog_meta;
   logic tog_sync;
   logic tog_seen;
   wire  new_load;

   assign new_load = tog_sync ^ tog_seen;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_seen <= 1'b0;
      end
      else
      begin
         tog_meta <= load_toggle;
         tog_sync <= tog_meta;
         tog_seen <= tog_sync;
      end
   end

   // Plain binary word, D0 weight one up to D7 weight 128
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         threshold_ref <= THR_RESET;
      else if (new_load)
         threshold_ref <= latch_word;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         threshold_loaded <= 1'b0;
      else
         threshold_loaded <= new_load;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         load_count <= LOADS_RESET;
      else if (new_load)
         load_count <= load_count + LOADS_STEP;
   end

   // ****************************************************************
   // Sample capacitor model
   // ****************************************************************
   // Tracks the selected channel while measuring and keeps the last
   // value once the mode is left, like the capacitor after the mux opens.
   logic [THR_W-1:0] held_sample;
   stl_chan_e        held_chan;
   logic [THR_W-1:0] next_held_sample;
   stl_chan_e        next_held_chan;

   assign next_held_sample = next_press ? press_sync :
                             next_temp  ? temp_sync  : held_sample;
   assign next_held_chan   = next_press ? CH_PRESSURE :
                             next_temp  ? CH_TEMP     : held_chan;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         held_sample <= SAMPLE_RESET;
         held_chan   <= CH_PRESSURE;
      end
      else
      begin
         held_sample <= next_held_sample;
         held_chan   <= next_held_chan;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         held_is_temp <= 1'b0;
      else
         held_is_temp <= (next_held_chan == CH_TEMP);
   end

   // ****************************************************************
   // Comparator
   // ****************************************************************
   // Powered only in read mode; low otherwise.
   wire sample_above;

   assign sample_above = (held_sample > threshold_ref);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         compare_out   <= 1'b0;
         compare_valid <= 1'b0;
      end
      else
      begin
         compare_out   <= next_read & sample_above;
         compare_valid <= next_read;
      end
   end

endmodule

// file: shared/stl_pkg.sv
// Shared constants for the serial threshold loader.
// Assumes: included by the loader top and its serial link module.

package stl_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int THR_W   = 8;
   localparam int CNT_W   = 4;
   localparam int MODE_W  = 2;

   // ****************************************************************
   // Threshold word layout: bit n has weight 2**n
   // ****************************************************************
   localparam int THR_MSB = 7;
   localparam int THR_LSB = 0;

   // ****************************************************************
   // Serial transfer counts
   // ****************************************************************
   localparam logic [CNT_W-1:0] BITS_PER_LOAD  = 4'h8;
   localparam logic [CNT_W-1:0] COUNT_CLEARED  = 4'h0;
   localparam logic [CNT_W-1:0] COUNT_FIRST    = 4'h1;
   localparam logic [CNT_W-1:0] COUNT_STEP     = 4'h1;

   // ****************************************************************
   // Mode pin codes {mode_select_high, mode_select_low}
   // ****************************************************************
   localparam logic [MODE_W-1:0] MODE_STANDBY  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_PRESSURE = 2'h1;
   localparam logic [MODE_W-1:0] MODE_TEMP     = 2'h2;
   localparam logic [MODE_W-1:0] MODE_READ     = 2'h3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [THR_W-1:0]  THR_RESET     = 8'h00;
   localparam logic [THR_W-1:0]  SAMPLE_RESET  = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RESET    = 2'h0;
   localparam logic [THR_W-1:0]  LOADS_RESET   = 8'h00;
   localparam logic [THR_W-1:0]  LOADS_STEP    = 8'h01;

   // ****************************************************************
   // Operating mode states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_STANDBY  = 4'b0001,
      ST_PRESSURE = 4'b0010,
      ST_TEMP     = 4'b0100,
      ST_READ     = 4'b1000
   } stl_mode_e;

   // Sampled channel held on the sample capacitor
   typedef enum logic [1:0] {
      CH_PRESSURE = 2'b01,
      CH_TEMP     = 2'b10
   } stl_chan_e;

endpackage

// file: hdl/stl_serial_link.sv
// Serial side of the threshold loader, clocked by the serial clock pin.
// Assumes: link_clear comes from a flop in the reference clock domain and
// is only asserted while the serial clock stands still (measure modes).
`timescale 1ns/1ps

module stl_serial_link
   import stl_pkg::*;
(
   input  wire logic             sclk,          // Serial clock pin
   input  wire logic             rst,           // System reset, async high
   input  wire logic             sdata,         // Serial data pin
   input  wire logic             link_clear,    // Bit counter clear, async high
   output logic [THR_W-1:0]      latch_word,    // Threshold latch contents
   output logic                  load_toggle    // Flips on every latch load
);

   // ****************************************************************
   // Shift register and bit counter
   // ****************************************************************
   logic [THR_W-1:0] shift_word;
   logic [CNT_W-1:0] bit_count;
   logic [CNT_W-1:0] next_bit_count;
   wire              byte_done;

   assign byte_done      = (bit_count == BITS_PER_LOAD);
   // Wrap so the next eight clocks form a fresh byte
   assign next_bit_count = byte_done ? COUNT_FIRST : bit_count + COUNT_STEP;

   // First bit in travels up to the top bit
   always_ff @(posedge sclk)
   begin
      shift_word <= {shift_word[THR_MSB-1:THR_LSB], sdata};
   end

   // No power-up clear: only the mode pins clear the counter
   always_ff @(posedge sclk or posedge link_clear)
   begin
      if (link_clear)
         bit_count <= COUNT_CLEARED;
      else
         bit_count <= next_bit_count;
   end

   // ****************************************************************
   // Threshold latch, loaded on the falling edge of the eighth clock
   // ****************************************************************
   // Latch has no reset and holds in every mode
   always_ff @(negedge sclk)
   begin
      if (byte_done)
         latch_word <= shift_word;
   end

   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
         load_toggle <= 1'b0;
      else if (byte_done)
         load_toggle <= ~load_toggle;
   end

endmodule

// file: sim/stl_threshold_loader_asserts.sv
// Concurrent checks on the ports of the threshold loader top.
// Assumes: bound to stl_threshold_loader; mode pins held at 00 in reset.
`timescale 1ns/1ps

module stl_threshold_loader_asserts
   import stl_pkg::*;
(
   input wire logic             ref_clk,          // Reference clock
   input wire logic             rst,              // Async reset, high
   input wire logic             mode_select_low,  // Mode pin, low bit
   input wire logic             mode_select_high, // Mode pin, high bit
   input wire logic [THR_W-1:0] threshold_ref,    // Threshold copy
   input wire logic             compare_out,      // Comparator result
   input wire logic             compare_valid,    // Read mode flag
   input wire logic             pressure_meas_en, // Pressure power
   input wire logic             temp_source_en,   // Temperature source
   input wire stl_mode_e        mode_state,       // Decoded mode
   input wire logic             threshold_loaded, // Load pulse
   input wire logic [THR_W-1:0] load_count        // Loads since reset
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_temp_src;
      temp_source_en == (mode_state == ST_TEMP);
   endproperty
   a_temp_src: assert property (p_temp_src) else $error("temp source wrong");
   property p_press_en;
      pressure_meas_en == (mode_state == ST_PRESSURE);
   endproperty
   a_press_en: assert property (p_press_en) else $error("pressure power wrong");
   property p_read_en;
      compare_valid == (mode_state == ST_READ);
   endproperty
   a_read_en: assert property (p_read_en) else $error("read flag wrong");
   property p_cmp_off;
      !compare_valid |-> !compare_out;
   endproperty
   a_cmp_off: assert property (p_cmp_off) else $error("compare out of read");
   property p_mode_dec;
      $stable({mode_select_high, mode_select_low})[*3]
         |-> mode_state == stl_mode_e'(4'h1 << {mode_select_high, mode_select_low});
   endproperty
   a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");
   property p_thr_hold;
      !threshold_loaded |-> $stable(threshold_ref);
   endproperty
   a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
   property p_pulse;
      threshold_loaded |=> !threshold_loaded;
   endproperty
   a_pulse: assert property (p_pulse) else $error("load pulse too long");
   property p_count;
      threshold_loaded |-> load_count == $past(load_count) + LOADS_STEP;
   endproperty
   a_count: assert property (p_count) else $error("load count wrong");
   property p_meas_quiet;
      (mode_state inside {ST_PRESSURE, ST_TEMP})[*4] |-> !threshold_loaded;
   endproperty
   a_meas_quiet: assert property (p_meas_quiet) else $error("load while measuring");
endmodule

bind stl_threshold_loader stl_threshold_loader_asserts u_chk (
   .ref_clk, .rst, .mode_select_low, .mode_select_high, .threshold_ref, .compare_out,
   .compare_valid, .pressure_meas_en, .temp_source_en, .mode_state, .threshold_loaded,
   .load_count
);

// file: sim/stl_mcu_model.sv
// Controller model driving the serial clock and data pins.
// Assumes: the bench calls send_bits only in standby or read mode.
`timescale 1ns/1ps

module stl_mcu_model
   import stl_pkg::*;
#(
   parameter int HALF_NS = 24   // Serial clock half period
)
(
   output logic sclk,           // Serial clock, idle low
   output logic sdata           // Serial data, pulled low
);
   initial
   begin
      sclk = 1'b0;
      sdata = 1'b0;
   end

   // Shift n bits of b, first bit is the most significant
   task automatic send_bits(input logic [THR_W-1:0] b, input int n, input int idle);
      #(idle);
      for (int i = THR_MSB; i > THR_MSB - n; i--)
      begin
         sdata = b[i];
         #(HALF_NS) sclk = 1'b1;
         #(HALF_NS) sclk = 1'b0;
      end
      sdata = 1'b0;                 // Released line falls to its pull-down
   endtask
endmodule

// file: sim/tb_stl_threshold_loader.sv
// Self-checking bench for the serial threshold loader.
// Assumes: stl_mcu_model drives the serial pins; the checker is bound.
`timescale 1ns/1ps

module tb_stl_threshold_loader
   import stl_pkg::*;
;
   logic             ref_clk = 1'b0;
   logic             rst = 1'b0;
   logic             sclk, sdata, compare_out, compare_valid;
   logic             pressure_meas_en, temp_source_en, held_is_temp, threshold_loaded;
   logic             mode_select_low = 1'b0;
   logic             mode_select_high = 1'b0;
   logic [THR_W-1:0] pressure_sample = 8'h00;
   logic [THR_W-1:0] temp_sample = 8'h00;
   logic [THR_W-1:0] threshold_ref, load_count, res;
   logic [THR_W-1:0] pats [4] = '{8'h01, 8'h80, 8'hA5, 8'h5A};
   stl_mode_e        mode_state;
   int               n_errors = 0;
   int               num_checks = 0;
   int               cycles = 0;

   always #20 ref_clk = ~ref_clk;

   stl_mcu_model mcu (.sclk(sclk), .sdata(sdata));

   stl_threshold_loader dut (
      .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .sdata(sdata),
      .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
      .pressure_sample(pressure_sample), .temp_sample(temp_sample),
      .threshold_ref(threshold_ref), .compare_out(compare_out),
      .compare_valid(compare_valid), .pressure_meas_en(pressure_meas_en),
      .temp_source_en(temp_source_en), .mode_state(mode_state),
      .held_is_temp(held_is_temp), .threshold_loaded(threshold_loaded),
      .load_count(load_count)
   );

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Mode outputs settle on the third edge after a pin change
   task automatic set_mode(input logic [MODE_W-1:0] m);
      @(posedge ref_clk);
      {mode_select_high, mode_select_low} <= m;
      repeat (4) @(posedge ref_clk);
   endtask

   // Full byte, then time for the sync, the copy and the comparator
   task automatic load(input logic [7:0] b);
      mcu.send_bits(b, 8, 7);
      repeat (6) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_errors++;
         test_done();
      end
   end

   initial
   begin
      // A real rising edge resets load_toggle while the serial clock stands still
      rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk(8'(mode_state), 8'(ST_STANDBY));
      set_mode(MODE_PRESSURE);
      set_mode(MODE_STANDBY);
      load(8'hFF);
      chk(threshold_ref, 8'hFF);
      load(8'h00);
      chk(threshold_ref, 8'h00);
      foreach (pats[i])
      begin
         load(pats[i]);
         chk(threshold_ref, pats[i]);
      end
      mcu.send_bits(8'h3C, 8, 7);
      // Half a period of idle stretches one low phase of the serial clock to a full period
      mcu.send_bits(8'hC3, 8, 24);
      repeat (6) @(posedge ref_clk);
      chk(threshold_ref, 8'hC3);
      chk(load_count, 8'h08);
      mcu.send_bits(8'hFF, 3, 7);
      set_mode(MODE_TEMP);
      set_mode(MODE_STANDBY);
      load(8'h42);
      chk(threshold_ref, 8'h42);
      for (int m = 0; m < 4; m++)
      begin
         set_mode(2'(m));
         chk(8'(mode_state), 8'(4'h1 << m));
         chk(8'(pressure_meas_en), 8'(m == 1));
         chk(8'(temp_source_en), 8'(m == 2));
         chk(8'(compare_valid), 8'(m == 3));
         chk(8'(compare_out), 8'h00);
         chk(threshold_ref, 8'h42);
      end
      temp_sample <= 8'h9B;
      set_mode(MODE_TEMP);
      set_mode(MODE_READ);
      chk(8'(held_is_temp), 8'h01);
      res = 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
         load(res | (8'h01 << i));
         if (compare_out === 1'b1)
            res = res | (8'h01 << i);
      end
      chk(res, 8'h9A);
      pressure_sample <= 8'h80;
      set_mode(MODE_PRESSURE);
      set_mode(MODE_READ);
      chk(8'(held_is_temp), 8'h00);
      load(8'h7F);
      chk(8'(compare_out), 8'h01);
      load(8'h80);
      chk(8'(compare_out), 8'h00);
      test_done();
   end
endmodule
